//--- design/cmg_defines.vh
/*
 * Constants for the processor memory and peripheral glue: register word
 * addresses, control and status bit positions, arbiter periods.
 * Assumes inclusion by bare name from plain Verilog design files.
 */
`ifndef CMG_DEFINES_VH
`define CMG_DEFINES_VH

// ****************************************
// Address decode
// ****************************************
`define CMG_MEM_WORDS 8192
`define CMG_MEM_AW 13
`define CMG_WIN_LO 16'h0020
`define CMG_WIN_HI 16'h003f

// ****************************************
// Register word addresses
// ****************************************
`define CMG_REG_IRQ_EN 16'h0020
`define CMG_REG_STATUS 16'h0021
`define CMG_REG_DEBUG_SER 16'h0022
`define CMG_REG_CONTROL 16'h0023
`define CMG_REG_SER_WORD 16'h0024
`define CMG_REG_KEY_BYTE 16'h0025
`define CMG_REG_DRIVE 16'h0026

// ****************************************
// Field positions
// ****************************************
`define CMG_ST_DEBUG_TX_BUSY 0
`define CMG_ST_SERIAL_BUSY 1
`define CMG_ST_KEY_VALID 2
`define CMG_ST_MODIFIED 15
`define CMG_CTL_CHIP_SELECT_N 0
`define CMG_CTL_DMA_EN 1
`define CMG_CTL_FAST 2
`define CMG_CTL_BUS_A 3
`define CMG_CTL_WR_ALLOW1 4
`define CMG_CTL_WR_ALLOW2 5
`define CMG_CTL_DRIVE_SEL 15

// ****************************************
// Reset values and arbiter timing
// ****************************************
`define CMG_CONTROL_RST 16'h0001
`define CMG_IRQ_EN_RST 16'h0000
`define CMG_VID_PERIOD 16
`define CMG_VID_SLOTS 2
`define CMG_DMA_PERIOD 1536
`define CMG_DMA_BITS 16

`endif

//--- design/cmg_glue.v
/*
 * Glue between a 16-bit word-addressed processor core and its memory,
 * video byte reader, disk DMA word port and peripheral registers.
 * Assumes the core issues one word access per cycle and stalls on gnt=0,
 * and that serial, debug serial and disk engines sit outside this block.
 */
`timescale 1ns/1ps
`include "cmg_defines.vh"

module cmg_glue (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Processor side
    input wire [15:0] cpu_addr,
    input wire [15:0] cpu_wdata,
    input wire cpu_we,
    input wire cpu_req,
    output wire cpu_gnt,
    output reg [15:0] cpu_rdata,
    // Video byte reader
    input wire vid_visible,
    input wire [13:0] vid_byte_addr,
    output wire vid_slot,
    output reg [7:0] vid_data,
    // Disk DMA word port
    input wire dma_bit_tick,
    input wire dma_bit_in,
    input wire dma_write_dir,
    input wire [12:0] dma_addr,
    output wire dma_slot,
    output reg [15:0] dma_rd_buf,
    output wire dma_bit_out,
    // Serial engine
    input wire [15:0] ser_rx_data,
    input wire ser_busy,
    output reg [15:0] ser_tx_data,
    output reg ser_start,
    output reg ser_len16,
    // Debug serial engine
    input wire [7:0] dbg_rx_data,
    input wire dbg_tx_busy,
    output reg [7:0] dbg_tx_data,
    output reg dbg_tx_start,
    // Keyboard and drive
    input wire [7:0] key_code,
    input wire key_valid,
    input wire drive_motor_on,
    input wire [3:0] phase_pins,
    input wire sector_write_evt,
    // Control and interrupt mask
    output wire [15:0] control,
    output wire [15:0] interrupt_enable_mask
);

    // ****************************************
    // Storage and state
    // ****************************************
    reg [15:0] mem [0:`CMG_MEM_WORDS-1];
    reg [15:0] control_q;
    reg [15:0] irq_en_q;
    reg modified_q;
    reg [3:0] phase_q;
    reg [3:0] phase_edge_q;
    reg ser_len16_q;
    reg [3:0] vid_cnt_q;
    reg [10:0] dma_cnt_q;
    reg [3:0] dma_bits_q;
    reg [15:0] dma_shift_q;
    reg [15:0] dma_wr_buf_q;
    reg dma_pend_q;
    reg [15:0] rd_word_q;
    reg rd_win_q;
    reg rd_swap_q;
    reg [15:0] reg_mux_q;
    reg vid_lsb_q;
    reg vid_rd_q;
    reg dma_rd_q;

    wire in_win;
    wire cpu_wr_mem;
    wire [12:0] mem_addr;
    wire [15:0] reg_rd;
    wire reg_wr;
    wire [3:0] phase_rise;

    assign control = control_q;
    assign interrupt_enable_mask = irq_en_q;
    assign dma_bit_out = dma_shift_q[15];

    // ****************************************
    // Arbiter
    // ****************************************
    // Video steals slots 0 and 1 of each 16-cycle group
    assign vid_slot = vid_visible && (vid_cnt_q < `CMG_VID_SLOTS);
    assign dma_slot = dma_pend_q && !vid_slot;
    assign cpu_gnt = cpu_req && !vid_slot && !dma_slot;

    // Window only when A15..A13 clear; memory never sees those bits
    assign in_win = (cpu_addr[15:13] == 3'b000) &&
                    (cpu_addr[12:0] >= `CMG_WIN_LO) &&
                    (cpu_addr[12:0] <= `CMG_WIN_HI);
    assign mem_addr = vid_slot ? vid_byte_addr[13:1] :
                      (dma_slot ? dma_addr : cpu_addr[12:0]);
    assign cpu_wr_mem = cpu_gnt && cpu_we && !in_win;
    assign reg_wr = cpu_gnt && cpu_we && in_win;

    always @(posedge clk_sys) begin
        if (cpu_wr_mem) begin
            mem[mem_addr] <= cpu_wdata;
        end else if (dma_slot && dma_write_dir) begin
            mem[mem_addr] <= dma_wr_buf_q;
        end
        rd_word_q <= mem[mem_addr];
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            vid_cnt_q <= 4'h0;
        end else if (vid_visible) begin
            vid_cnt_q <= vid_cnt_q + 4'h1;
        end else begin
            vid_cnt_q <= 4'h0;
        end
    end

    // ****************************************
    // Disk DMA
    // ****************************************
    // Words move after 16 bits; pending stays until a slot is free
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dma_cnt_q <= 11'h000;
            dma_bits_q <= 4'h0;
            dma_shift_q <= 16'h0000;
            dma_wr_buf_q <= 16'h0000;
            dma_pend_q <= 1'b0;
        end else if (!control_q[`CMG_CTL_DMA_EN]) begin
            dma_cnt_q <= 11'h000;
            dma_bits_q <= 4'h0;
            dma_pend_q <= 1'b0;
        end else begin
            if (dma_cnt_q == 11'd`CMG_DMA_PERIOD - 11'd1) begin
                dma_cnt_q <= 11'h000;
            end else begin
                dma_cnt_q <= dma_cnt_q + 11'h001;
            end
            // A served slot clears; a word completing in that cycle wins
            if (dma_slot) begin
                dma_pend_q <= 1'b0;
            end
            if (dma_bit_tick) begin
                dma_shift_q <= {dma_shift_q[14:0], dma_bit_in};
                dma_bits_q <= dma_bits_q + 4'h1;
                if (dma_bits_q == 4'hf) begin
                    dma_wr_buf_q <= {dma_shift_q[14:0], dma_bit_in};
                    dma_pend_q <= 1'b1;
                end
            end
            if (dma_rd_q) begin
                dma_shift_q <= rd_word_q;
            end
        end
    end

    // ****************************************
    // Peripheral registers
    // ****************************************
    assign phase_rise = phase_pins & ~phase_q;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            control_q <= `CMG_CONTROL_RST;
            irq_en_q <= `CMG_IRQ_EN_RST;
            modified_q <= 1'b0;
            phase_q <= 4'h0;
            phase_edge_q <= 4'h0;
            ser_len16_q <= 1'b0;
            ser_tx_data <= 16'h0000;
            ser_start <= 1'b0;
            ser_len16 <= 1'b0;
            dbg_tx_data <= 8'h00;
            dbg_tx_start <= 1'b0;
        end else begin
            ser_start <= 1'b0;
            dbg_tx_start <= 1'b0;
            phase_q <= phase_pins;
            // Set wins over a same-cycle clear strobe
            phase_edge_q <= (reg_wr && cpu_addr[5:0] == `CMG_REG_STATUS) ?
                            phase_rise : (phase_edge_q | phase_rise);
            if (sector_write_evt) begin
                modified_q <= 1'b1;
            end else if (reg_wr && cpu_addr[5:0] == `CMG_REG_KEY_BYTE) begin
                modified_q <= 1'b0;
            end
            if (reg_wr) begin
                case (cpu_addr[5:0])
                    `CMG_REG_IRQ_EN: begin
                        irq_en_q <= cpu_wdata;
                    end
                    `CMG_REG_DEBUG_SER: begin
                        dbg_tx_data <= cpu_wdata[7:0];
                        dbg_tx_start <= 1'b1;
                    end
                    `CMG_REG_CONTROL: begin
                        control_q <= cpu_wdata;
                    end
                    `CMG_REG_SER_WORD: begin
                        ser_tx_data <= cpu_wdata;
                        ser_len16 <= 1'b1;
                        ser_len16_q <= 1'b1;
                        ser_start <= 1'b1;
                    end
                    `CMG_REG_KEY_BYTE: begin
                        // Byte sent left-aligned, MSB first on the wire
                        ser_tx_data <= {cpu_wdata[7:0], 8'h00};
                        ser_len16 <= 1'b0;
                        ser_len16_q <= 1'b0;
                        ser_start <= 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Register read mux; unlisted window words read zero
    assign reg_rd =
        (cpu_addr[5:0] == `CMG_REG_IRQ_EN) ? irq_en_q :
        (cpu_addr[5:0] == `CMG_REG_STATUS) ?
            {modified_q, 12'h000, key_valid, ser_busy, dbg_tx_busy} :
        (cpu_addr[5:0] == `CMG_REG_DEBUG_SER) ? {8'h00, dbg_rx_data} :
        (cpu_addr[5:0] == `CMG_REG_CONTROL) ? control_q :
        (cpu_addr[5:0] == `CMG_REG_SER_WORD) ?
            (ser_len16_q ? ser_rx_data : {8'h00, ser_rx_data[7:0]}) :
        (cpu_addr[5:0] == `CMG_REG_KEY_BYTE) ? {8'h00, key_code} :
        (cpu_addr[5:0] == `CMG_REG_DRIVE) ?
            {drive_motor_on, 11'h000, phase_edge_q} :
        16'h0000;

    // ****************************************
    // Read return paths
    // ****************************************
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_win_q <= 1'b0;
            rd_swap_q <= 1'b0;
            reg_mux_q <= 16'h0000;
            vid_lsb_q <= 1'b0;
            vid_rd_q <= 1'b0;
            dma_rd_q <= 1'b0;
        end else begin
            rd_win_q <= in_win;
            rd_swap_q <= cpu_addr[15];
            reg_mux_q <= reg_rd;
            vid_lsb_q <= vid_byte_addr[0];
            vid_rd_q <= vid_slot;
            dma_rd_q <= dma_slot && !dma_write_dir;
        end
    end

    always @* begin
        if (rd_win_q) begin
            cpu_rdata = reg_mux_q;
        end else if (rd_swap_q) begin
            cpu_rdata = {rd_word_q[7:0], rd_word_q[15:8]};
        end else begin
            cpu_rdata = rd_word_q;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            vid_data <= 8'h00;
            dma_rd_buf <= 16'h0000;
        end else begin
            if (vid_rd_q) begin
                vid_data <= vid_lsb_q ? rd_word_q[7:0] : rd_word_q[15:8];
            end
            if (dma_rd_q) begin
                dma_rd_buf <= rd_word_q;
            end
        end
    end

endmodule

//--- test/cmg_glue_monitor.sv
/* Port assertions for the processor glue.
   Assumes a bind onto cmg_glue and one clock. */
`timescale 1ns/1ps
module cmg_glue_monitor (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Watched ports
    input wire [15:0] cpu_addr,
    input wire [15:0] cpu_wdata,
    input wire cpu_we,
    input wire cpu_req,
    input wire cpu_gnt,
    input wire [15:0] cpu_rdata,
    input wire vid_visible,
    input wire vid_slot,
    input wire dma_slot,
    input wire [15:0] ser_tx_data,
    input wire ser_start,
    input wire ser_len16,
    input wire [7:0] key_code,
    input wire key_valid,
    input wire ser_busy,
    input wire dbg_tx_busy
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire rd_ok = cpu_gnt && !cpu_we;
    wire wr_ok = cpu_gnt && cpu_we;
    a_vid_blocks: assert property (vid_slot |-> !cpu_gnt && !dma_slot)
        else $error("video slot not exclusive");
    a_dma_blocks: assert property (dma_slot |-> !cpu_gnt)
        else $error("grant during dma slot");
    a_core_served: assert property (cpu_req && !vid_slot && !dma_slot |-> cpu_gnt)
        else $error("free cycle not granted");
    a_key_read: assert property (rd_ok && cpu_addr == 16'h0025
        |=> cpu_rdata == {8'h00, $past(key_code)}) else $error("key read wrong");
    a_status_read: assert property (rd_ok && cpu_addr == 16'h0021
        |=> cpu_rdata[2:0] == $past({key_valid, ser_busy, dbg_tx_busy}))
        else $error("status read wrong");
    a_word_send: assert property (wr_ok && cpu_addr == 16'h0024
        |=> ser_start && ser_len16 && ser_tx_data == $past(cpu_wdata) ##1 !ser_start)
        else $error("word transfer start wrong");
    a_byte_send: assert property (wr_ok && cpu_addr == 16'h0025
        |=> ser_start && !ser_len16 && ser_tx_data[15:8] == $past(cpu_wdata[7:0]))
        else $error("byte transfer start wrong");
    a_vid_pair: assert property ($rose(vid_slot) ##1 vid_visible |-> vid_slot ##1 !vid_slot)
        else $error("video slot length wrong");
endmodule

//--- test/cmg_cpu_model.sv
/* Processor core model: one word access per call.
   Assumes the bench calls access shortly after a rising edge. */
`timescale 1ns/1ps
module cmg_cpu_model (
    // Clock
    input wire clk_sys,
    // Bus
    input wire cpu_gnt,
    input wire [15:0] cpu_rdata,
    output reg [15:0] cpu_addr,
    output reg [15:0] cpu_wdata,
    output reg cpu_we,
    output reg cpu_req
);
    initial begin
        cpu_addr = 16'h0000;
        cpu_wdata = 16'h0000;
        cpu_we = 1'b0;
        cpu_req = 1'b0;
    end
    task access(input [15:0] a, input w, input [15:0] d, output [15:0] q);
        reg g;
        begin
            @(posedge clk_sys);
            #1;
            cpu_addr = a;
            cpu_wdata = d;
            cpu_we = w;
            cpu_req = 1'b1;
            g = 1'b0;
            // Request held through refusals
            while (!g) begin
                @(negedge clk_sys);
                g = (cpu_gnt === 1'b1);
                @(posedge clk_sys);
            end
            #1;
            q = cpu_rdata;
            cpu_req = 1'b0;
            cpu_we = 1'b0;
            cpu_wdata = ~d;
        end
    endtask
endmodule

//--- test/tb.sv
/* Self-checking bench for cmg_glue.
   Assumes the core model and checker files are compiled first. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
    reg clk_sys = 1'b0;
    reg rst_n = 1'b0;
    reg vid_visible = 1'b1;
    reg [13:0] vid_byte_addr = 14'h0108;
    reg dma_bit_tick = 1'b0, dma_bit_in = 1'b0, dma_write_dir = 1'b1;
    reg [12:0] dma_addr = 13'h0100;
    reg [15:0] ser_rx_data = 16'h5a3c;
    reg ser_busy = 1'b0, key_valid = 1'b1, drive_motor_on = 1'b1;
    reg [7:0] key_code = 8'h5b;
    reg [7:0] dbg_rx_data = 8'h6d;
    reg [3:0] phase_pins = 4'h0;
    reg sector_write_evt = 1'b0;
    wire [15:0] cpu_addr, cpu_wdata, cpu_rdata, control, interrupt_enable_mask;
    wire cpu_we, cpu_req, cpu_gnt, vid_slot, dma_slot;
    wire [7:0] vid_data;
    wire [15:0] ser_tx_data;
    wire [15:0] dma_rd_buf;
    wire [7:0] dbg_tx_data;
    wire dma_bit_out;
    integer bad_count = 0, n_tests = 0, cyc = 0, i, n;
    cmg_glue DUT (.clk_sys(clk_sys), .rst_n(rst_n), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_we(cpu_we), .cpu_req(cpu_req), .cpu_gnt(cpu_gnt),
        .cpu_rdata(cpu_rdata), .vid_visible(vid_visible), .vid_byte_addr(vid_byte_addr),
        .vid_slot(vid_slot), .vid_data(vid_data), .dma_bit_tick(dma_bit_tick),
        .dma_bit_in(dma_bit_in), .dma_write_dir(dma_write_dir), .dma_addr(dma_addr),
        .dma_slot(dma_slot), .dma_rd_buf(dma_rd_buf), .dma_bit_out(dma_bit_out),
        .ser_rx_data(ser_rx_data),
        .ser_busy(ser_busy), .ser_tx_data(ser_tx_data), .ser_start(), .ser_len16(),
        .dbg_rx_data(dbg_rx_data), .dbg_tx_busy(1'b0), .dbg_tx_data(dbg_tx_data),
        .dbg_tx_start(),
        .key_code(key_code), .key_valid(key_valid), .drive_motor_on(drive_motor_on),
        .phase_pins(phase_pins), .sector_write_evt(sector_write_evt), .control(control),
        .interrupt_enable_mask(interrupt_enable_mask));
    cmg_cpu_model u_cpu (.clk_sys(clk_sys), .cpu_gnt(cpu_gnt), .cpu_rdata(cpu_rdata),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_we(cpu_we), .cpu_req(cpu_req));
    initial forever #2.5 clk_sys = ~clk_sys;
    task wr(input [15:0] a, input [15:0] d);
        reg [15:0] q;
        u_cpu.access(a, 1'b1, d, q);
    endtask
    task rc(input string nm, input [15:0] a, input [15:0] e);
        reg [15:0] q;
        begin
            u_cpu.access(a, 1'b0, 16'h0000, q);
            `CHK(nm, e, q)
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Video slots keep stealing cycles in every test
    task t_swap;
        wr(16'h0084, 16'h3078);
        rc("plain", 16'h0084, 16'h3078);
        rc("swapped", 16'h8084, 16'h7830);
        wr(16'h8085, 16'h1234);
        rc("write_high", 16'h0085, 16'h1234);
        $display("test swap done");
    endtask
    task t_window;
        wr(16'h2020, 16'hbeef);
        wr(16'h0020, 16'h00a5);
        rc("mask", 16'h0020, 16'h00a5);
        `CHK("mask_port", 16'h00a5, interrupt_enable_mask)
        rc("alias2", 16'h2020, 16'hbeef);
        rc("alias4", 16'h4020, 16'hbeef);
        rc("alias6", 16'h6020, 16'hbeef);
        rc("unlisted", 16'h0030, 16'h0000);
        $display("test window done");
    endtask
    task t_regs;
        rc("ctl_reset", 16'h0023, 16'h0001);
        wr(16'h0023, 16'h8031);
        rc("ctl", 16'h0023, 16'h8031);
        `CHK("ctl_port", 16'h8031, control)
        rc("key", 16'h0025, 16'h005b);
        rc("status", 16'h0021, 16'h0004);
        rc("drive", 16'h0026, 16'h8000);
        wr(16'h0022, 16'h1234);
        `CHK("dbg_tx", 8'h34, dbg_tx_data)
        rc("dbg_rx", 16'h0022, 16'h006d);
        $display("test regs done");
    endtask
    task t_serial;
        wr(16'h0024, 16'hc3a5);
        rc("rx16", 16'h0024, 16'h5a3c);
        wr(16'h0025, 16'h0081);
        `CHK("tx8", 8'h81, ser_tx_data[15:8])
        rc("rx8", 16'h0024, 16'h003c);
        $display("test serial done");
    endtask
    // One-cycle flag events, then data-ignoring clear strobes
    task t_flags;
        phase_pins = 4'h5;
        sector_write_evt = 1'b1;
        @(posedge clk_sys);
        #1 sector_write_evt = 1'b0;
        phase_pins = 4'h0;
        rc("sector_modified_flag_set", 16'h0021, 16'h8004);
        rc("edges_set", 16'h0026, 16'h8005);
        wr(16'h0021, 16'hffff);
        rc("edges_clr", 16'h0026, 16'h8000);
        wr(16'h0025, 16'hffff);
        rc("sector_modified_flag_clr", 16'h0021, 16'h0004);
        $display("test flags done");
    endtask
    task t_video;
        n = 0;
        repeat (32) begin
            @(posedge clk_sys);
            #1 n = n + vid_slot;
        end
        `CHK("vid_slots", 4, n)
        repeat (20) @(posedge clk_sys);
        #1;
        `CHK("vid_even", 8'h30, vid_data)
        vid_byte_addr = 14'h0109;
        repeat (20) @(posedge clk_sys);
        #1;
        `CHK("vid_odd", 8'h78, vid_data)
        $display("test video done");
    endtask
    // Slots are counted from the first tick, so an early one is not missed
    task dma_shift(input [15:0] pat);
        begin
            n = 0;
            for (i = 15; i >= 0; i = i - 1) begin
                dma_bit_in = pat[i];
                dma_bit_tick = 1'b1;
                @(posedge clk_sys);
                #1 dma_bit_tick = 1'b0;
                n = n + dma_slot;
                @(posedge clk_sys);
                #1 n = n + dma_slot;
            end
            repeat (40) begin
                @(posedge clk_sys);
                #1 n = n + dma_slot;
            end
        end
    endtask
    task t_dma;
        wr(16'h0023, 16'h0003);
        dma_shift(16'h9b4e);
        `CHK("dma_slots", 1, n)
        rc("dma_word", 16'h0100, 16'h9b4e);
        dma_write_dir = 1'b0;
        dma_shift(16'h0000);
        `CHK("dma_rd_slots", 1, n)
        `CHK("dma_rd_buf", 16'h9b4e, dma_rd_buf)
        `CHK("dma_bit_out", 1'b1, dma_bit_out)
        $display("test dma done");
    endtask
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            wrap_up;
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        t_swap;
        t_window;
        t_regs;
        t_serial;
        t_flags;
        t_video;
        t_dma;
        wrap_up;
    end
endmodule
bind cmg_glue cmg_glue_monitor u_mon (.clk_sys(clk_sys), .rst_n(rst_n),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_we(cpu_we), .cpu_req(cpu_req),
    .cpu_gnt(cpu_gnt), .cpu_rdata(cpu_rdata), .vid_visible(vid_visible),
    .vid_slot(vid_slot), .dma_slot(dma_slot), .ser_tx_data(ser_tx_data),
    .ser_start(ser_start), .ser_len16(ser_len16), .key_code(key_code),
    .key_valid(key_valid), .ser_busy(ser_busy), .dbg_tx_busy(dbg_tx_busy));
